// ==== design/hsc_cfg.svh ====
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH

// ====================================================================
// Register byte offsets
`define HSC_OFS_MODE      12'h000
`define HSC_OFS_TLIMIT    12'h004
`define HSC_OFS_OFFSET    12'h008
`define HSC_OFS_OFSTYPE   12'h00C
`define HSC_OFS_STATUS    12'h010
`define HSC_OFS_ABSPOS    12'h014
`define HSC_NUM_REGS      6

// ====================================================================
// Register indexes (byte offset / 4)
`define HSC_IDX_MODE      3'h0
`define HSC_IDX_TLIMIT    3'h1
`define HSC_IDX_OFFSET    3'h2
`define HSC_IDX_OFSTYPE   3'h3

// ====================================================================
// Field layout
`define HSC_MODE_W        4
`define HSC_TLIM_W        16
`define HSC_OFSTYPE_W     2
`define HSC_ST_ACTIVE_BIT 0
`define HSC_ST_DONE_BIT   1
`define HSC_ST_FAULT_BIT  2
`define HSC_ST_SEEN_BIT   3
`define HSC_ST_STATE_LSB  4

// ====================================================================
// Homing mode codes
`define HSC_MODE_OFF      4'h0
`define HSC_MODE_START_A  4'h1
`define HSC_MODE_START_B  4'h2
`define HSC_MODE_FIRST_ON 4'h3
`define HSC_MODE_AUTO_A   4'h4
`define HSC_MODE_AUTO_B   4'h5
`define HSC_MODE_HERE     4'h6
`define HSC_MODE_DI_CAP   4'h8

// Offset type codes that apply the offset
`define HSC_OFSTYPE_APPLY_A 2'h0
`define HSC_OFSTYPE_APPLY_B 2'h2

// ====================================================================
// Reset values
`define HSC_MODE_RST      4'h0
`define HSC_TLIM_RST      16'h2710
`define HSC_OFFSET_RST    32'h0000_0000
`define HSC_OFSTYPE_RST   2'h0

// ====================================================================
// Timing
`define HSC_CLK_PERIOD_NS 100
`define HSC_MS_IN_NS      1000000
`define HSC_MS_CYCLES     (`HSC_MS_IN_NS / `HSC_CLK_PERIOD_NS)

`endif

// ==== design/hsc_pkg.sv ====
package hsc_pkg;

  // ==================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    HSC_IDLE  = 3'b001,
    HSC_RUN   = 3'b010,
    HSC_FAULT = 3'b100
  } hsc_state_type;

  // ==================================================================
  // APB request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } hsc_apb_req_type;

  // Decoded register write
  typedef struct packed {
    logic        wr;
    logic [2:0]  idx;
    logic [31:0] wdata;
  } hsc_reg_wr_type;

endpackage

// ==== design/hsc_apb_slave.sv ====
`timescale 1ns/1ps
`include "hsc_cfg.svh"

module hsc_apb_slave #(
  parameter int NREG = `HSC_NUM_REGS
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       ce,
  input  wire hsc_pkg::hsc_apb_req_type   req,
  input  wire logic [NREG-1:0][31:0]      rd_words,
  output logic                            pready,
  output logic                            pslverr,
  output logic [31:0]                     prdata,
  output hsc_pkg::hsc_reg_wr_type         reg_wr
);
  import hsc_pkg::*;

  logic        mapped;
  logic [2:0]  idx;
  logic [31:0] prdata_d;
  logic [31:0] prdata_q;

  // ==================================================================
  // Address decode
  assign idx     = req.addr[4:2];
  assign mapped  = (req.addr[11:5] == 7'h00) && (req.addr[1:0] == 2'h0) &&
                   (32'(idx) < NREG);
  // Access phase completes in one cycle unless frozen
  assign pready  = req.sel & req.enable & ce;
  assign pslverr = pready & ~mapped;
  assign prdata  = prdata_q;

  // Write strobe at the completing edge only
  always_comb begin
    reg_wr.wr    = pready & req.write & mapped;
    reg_wr.idx   = idx;
    reg_wr.wdata = req.wdata;
  end

  // Read word captured during setup phase
  always_comb begin
    prdata_d = prdata_q;
    if (req.sel && !req.enable && !req.write) begin
      prdata_d = mapped ? rd_words[idx] : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      prdata_q <= prdata_d;
    end
  end

endmodule // hsc_apb_slave

// ==== design/hsc_ms_timer.sv ====
`timescale 1ns/1ps
`include "hsc_cfg.svh"

module hsc_ms_timer #(
  parameter int MS_CYCLES = `HSC_MS_CYCLES,
  parameter int LIM_W     = `HSC_TLIM_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             restart,
  input  wire logic             run,
  input  wire logic [LIM_W-1:0] limit,
  output logic                  expired
);
  import hsc_pkg::*;

  logic [31:0]    presc_q;
  logic [31:0]    presc_d;
  logic [LIM_W:0] ms_q;
  logic [LIM_W:0] ms_d;
  logic           exp_q;
  logic           exp_d;

  assign expired = exp_q;

  // Millisecond prescaler and elapsed count, zeroed per run
  always_comb begin
    presc_d = presc_q;
    ms_d    = ms_q;
    exp_d   = exp_q;
    if (restart) begin
      presc_d = 32'h0000_0000;
      ms_d    = '0;
      exp_d   = 1'b0;
    end else if (run) begin
      if (presc_q == 32'(MS_CYCLES - 1)) begin
        presc_d = 32'h0000_0000;
        if (!ms_q[LIM_W]) begin
          ms_d = ms_q + 1'b1;
        end
      end else begin
        presc_d = presc_q + 32'h0000_0001;
      end
      exp_d = (ms_q > {1'b0, limit});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 32'h0000_0000;
      ms_q    <= '0;
      exp_q   <= 1'b0;
    end else if (ce) begin
      presc_q <= presc_d;
      ms_q    <= ms_d;
      exp_q   <= exp_d;
    end
  end

endmodule // hsc_ms_timer

// ==== design/hsc_top.sv ====
// Summary of operation
// - Start input transitions are ignored while a run is in progress.
// - Modes 1/2: servo_on low stops; restart needs servo_on then start.
// - Modes 1/2: timeout stops motor; new start edge clears fault and reruns.
// - Modes 1/2 accept any number of repeated runs.
// - Mode 3 runs only on the first servo_on after power-on.
// - Mode 3 timeout stops the motor; fault clears when servo_on drops.
// - Mode 3 cannot rerun until the next power-on.
// - Modes 4/5 start a run at once when servo_on rises.
// - Modes 4/5: servo_on low halts at once; raising it reruns.
// - Modes 4/5 timeout zeroes mode, stops; servo_on low clears fault.
// - Modes 4/5 write mode zero after a successful run.
// - Mode 6 sets present position home, using offset if type 0/2, nonzero.
// - Mode 6 then writes mode zero; rerun needs only the mode rewritten.
// - Fault raised when run exceeds programmable millisecond time limit.
// - Done flag set after homing in position mode, else low.
`timescale 1ns/1ps
`include "hsc_cfg.svh"

module hsc_top #(
  parameter int MS_CYCLES = `HSC_MS_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        servo_on,
  input  wire logic        homing_start_input,
  input  wire logic        home_reached,
  input  wire logic        position_mode,
  input  wire logic        di_position_capture_home,
  input  wire logic [31:0] motor_position,
  output logic             homing_active,
  output logic             homing_done_flag,
  output logic             homing_timeout_fault,
  output logic [31:0]      absolute_motor_position
);
  import hsc_pkg::*;

  // ==================================================================
  // Declarations
  hsc_apb_req_type               apb_req;
  hsc_reg_wr_type                reg_wr;
  logic [`HSC_NUM_REGS-1:0][31:0] rd_words;

  hsc_state_type                 st_q;
  hsc_state_type                 st_d;
  logic [`HSC_MODE_W-1:0]        mode_q;
  logic [`HSC_MODE_W-1:0]        mode_d;
  logic [`HSC_MODE_W-1:0]        run_mode_q;
  logic [`HSC_MODE_W-1:0]        run_mode_d;
  logic [`HSC_TLIM_W-1:0]        tlim_q;
  logic [`HSC_TLIM_W-1:0]        tlim_d;
  logic [31:0]                   offset_q;
  logic [31:0]                   offset_d;
  logic [`HSC_OFSTYPE_W-1:0]     ofstype_q;
  logic [`HSC_OFSTYPE_W-1:0]     ofstype_d;
  logic [31:0]                   home_q;
  logic [31:0]                   home_d;
  logic [31:0]                   ofs_used_q;
  logic [31:0]                   ofs_used_d;
  logic [31:0]                   abs_q;
  logic [31:0]                   abs_d;
  logic                          fault_q;
  logic                          fault_d;
  logic                          done_q;
  logic                          done_d;
  logic                          son_seen_q;
  logic                          son_seen_d;
  logic                          son_prev_q;
  logic                          start_prev_q;
  logic                          cap_prev_q;

  logic                          son_rise;
  logic                          start_rise;
  logic                          cap_rise;
  logic                          restart;
  logic                          expired;
  logic [31:0]                   ofs_apply;

  // ==================================================================
  // Mode classification helpers
  function automatic logic is_start_mode(input logic [`HSC_MODE_W-1:0] m);
    is_start_mode = (m == `HSC_MODE_START_A) || (m == `HSC_MODE_START_B);
  endfunction

  function automatic logic is_auto_mode(input logic [`HSC_MODE_W-1:0] m);
    is_auto_mode = (m == `HSC_MODE_AUTO_A) || (m == `HSC_MODE_AUTO_B);
  endfunction

  // ==================================================================
  // Bus slave
  always_comb begin
    apb_req.sel    = psel;
    apb_req.enable = penable;
    apb_req.write  = pwrite;
    apb_req.addr   = paddr;
    apb_req.wdata  = pwdata;
  end

  // Read-back words
  always_comb begin
    rd_words    = '0;
    rd_words[0] = {28'h000_0000, mode_q};
    rd_words[1] = {16'h0000, tlim_q};
    rd_words[2] = offset_q;
    rd_words[3] = {30'h0000_0000, ofstype_q};
    rd_words[4][`HSC_ST_ACTIVE_BIT]    = (st_q == HSC_RUN);
    rd_words[4][`HSC_ST_DONE_BIT]      = done_q;
    rd_words[4][`HSC_ST_FAULT_BIT]     = fault_q;
    rd_words[4][`HSC_ST_SEEN_BIT]      = son_seen_q;
    rd_words[4][`HSC_ST_STATE_LSB+:3]  = st_q;
    rd_words[5] = abs_q;
  end

  hsc_apb_slave #(
    .NREG     (`HSC_NUM_REGS)
  ) u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .req      (apb_req),
    .rd_words (rd_words),
    .pready   (pready),
    .pslverr  (pslverr),
    .prdata   (prdata),
    .reg_wr   (reg_wr)
  );

  // ==================================================================
  // Run timer
  hsc_ms_timer #(
    .MS_CYCLES (MS_CYCLES),
    .LIM_W     (`HSC_TLIM_W)
  ) u_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .restart   (restart),
    .run       (st_q == HSC_RUN),
    .limit     (tlim_q),
    .expired   (expired)
  );

  // ==================================================================
  // Input edges
  assign son_rise   = servo_on & ~son_prev_q;
  assign start_rise = homing_start_input & ~start_prev_q;
  assign cap_rise   = di_position_capture_home & ~cap_prev_q;

  // Offset applied only for the enabling types and a nonzero value
  assign ofs_apply = (((ofstype_q == `HSC_OFSTYPE_APPLY_A) ||
                       (ofstype_q == `HSC_OFSTYPE_APPLY_B)) &&
                      (offset_q != 32'h0000_0000)) ? offset_q : ofs_used_q;

  // ==================================================================
  // Sequencer next state
  always_comb begin
    st_d       = st_q;
    mode_d     = mode_q;
    run_mode_d = run_mode_q;
    tlim_d     = tlim_q;
    offset_d   = offset_q;
    ofstype_d  = ofstype_q;
    home_d     = home_q;
    ofs_used_d = ofs_used_q;
    fault_d    = fault_q;
    done_d     = done_q & position_mode;
    son_seen_d = son_seen_q | son_rise;
    restart    = 1'b0;
    unique case (st_q)
      HSC_IDLE: begin
        // Start only with servo on already present
        if (is_start_mode(mode_q) && servo_on && start_rise) begin
          st_d       = HSC_RUN;
          run_mode_d = mode_q;
          restart    = 1'b1;
          done_d     = 1'b0;
        end else if ((mode_q == `HSC_MODE_FIRST_ON) && son_rise &&
                     !son_seen_q) begin
          st_d       = HSC_RUN;
          run_mode_d = mode_q;
          restart    = 1'b1;
          done_d     = 1'b0;
        end else if (is_auto_mode(mode_q) && son_rise) begin
          st_d       = HSC_RUN;
          run_mode_d = mode_q;
          restart    = 1'b1;
          done_d     = 1'b0;
        end else if (mode_q == `HSC_MODE_HERE) begin
          // Present position becomes home, then mode self-clears
          home_d     = motor_position;
          ofs_used_d = ofs_apply;
          done_d     = position_mode;
          mode_d     = `HSC_MODE_OFF;
        end else if ((mode_q == `HSC_MODE_DI_CAP) && cap_rise) begin
          // Captured position becomes home, mode stays armed
          home_d     = motor_position;
          ofs_used_d = ofs_apply;
          done_d     = position_mode;
        end
      end
      HSC_RUN: begin
        // Start input not looked at while running
        if (!servo_on) begin
          st_d = HSC_IDLE;
        end else if (home_reached) begin
          st_d       = HSC_IDLE;
          home_d     = motor_position;
          ofs_used_d = ofs_apply;
          done_d     = position_mode;
          if (is_auto_mode(run_mode_q)) begin
            mode_d = `HSC_MODE_OFF;
          end
        end else if (expired) begin
          st_d    = HSC_FAULT;
          fault_d = 1'b1;
          if (is_auto_mode(run_mode_q)) begin
            mode_d = `HSC_MODE_OFF;
          end
        end
      end
      HSC_FAULT: begin
        if (is_start_mode(run_mode_q)) begin
          // Fresh start edge clears the fault and reruns
          if (servo_on && start_rise && is_start_mode(mode_q)) begin
            st_d       = HSC_RUN;
            run_mode_d = mode_q;
            fault_d    = 1'b0;
            restart    = 1'b1;
          end
        end else if (!servo_on) begin
          st_d    = HSC_IDLE;
          fault_d = 1'b0;
        end
      end
      default: begin
        st_d = HSC_IDLE;
      end
    endcase
    // Software writes last so a new mode beats a hardware clear
    if (reg_wr.wr) begin
      unique case (reg_wr.idx)
        `HSC_IDX_MODE:    mode_d    = reg_wr.wdata[`HSC_MODE_W-1:0];
        `HSC_IDX_TLIMIT:  tlim_d    = reg_wr.wdata[`HSC_TLIM_W-1:0];
        `HSC_IDX_OFFSET:  offset_d  = reg_wr.wdata;
        `HSC_IDX_OFSTYPE: ofstype_d = reg_wr.wdata[`HSC_OFSTYPE_W-1:0];
        default:          mode_d    = mode_d;
      endcase
    end
  end

  // Reported absolute position follows home and offset
  assign abs_d = motor_position - home_q + ofs_used_q;

  // ==================================================================
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q         <= HSC_IDLE;
      mode_q       <= `HSC_MODE_RST;
      run_mode_q   <= `HSC_MODE_RST;
      tlim_q       <= `HSC_TLIM_RST;
      offset_q     <= `HSC_OFFSET_RST;
      ofstype_q    <= `HSC_OFSTYPE_RST;
      home_q       <= 32'h0000_0000;
      ofs_used_q   <= 32'h0000_0000;
      abs_q        <= 32'h0000_0000;
      fault_q      <= 1'b0;
      done_q       <= 1'b0;
      son_seen_q   <= 1'b0;
      son_prev_q   <= 1'b0;
      start_prev_q <= 1'b0;
      cap_prev_q   <= 1'b0;
    end else if (ce) begin
      st_q         <= st_d;
      mode_q       <= mode_d;
      run_mode_q   <= run_mode_d;
      tlim_q       <= tlim_d;
      offset_q     <= offset_d;
      ofstype_q    <= ofstype_d;
      home_q       <= home_d;
      ofs_used_q   <= ofs_used_d;
      abs_q        <= abs_d;
      fault_q      <= fault_d;
      done_q       <= done_d;
      son_seen_q   <= son_seen_d;
      son_prev_q   <= servo_on;
      start_prev_q <= homing_start_input;
      cap_prev_q   <= di_position_capture_home;
    end
  end

  // ==================================================================
  // Outputs
  assign homing_active           = (st_q == HSC_RUN);
  assign homing_done_flag        = done_q;
  assign homing_timeout_fault    = fault_q;
  assign absolute_motor_position = abs_q;

endmodule // hsc_top

// ==== test/hsc_chk.sv ====
`timescale 1ns/1ps
// ==================================================================
// Port-level checks of the homing sequencer
module hsc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic servo_on,
  input wire logic homing_start_input,
  input wire logic home_reached,
  input wire logic position_mode,
  input wire logic homing_active,
  input wire logic homing_done_flag,
  input wire logic homing_timeout_fault
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A run only ends on home found, servo drop or timeout
  chk_run_holds: assert property (homing_active && servo_on && !home_reached
    |=> homing_active || homing_timeout_fault) else $error("run ended without cause");
  // Servo drop stops the motor on the next edge
  chk_son_stops: assert property (homing_active && !servo_on && ce
    |=> !homing_active) else $error("motor kept running after servo off");
  // A run starts only with servo enabled
  chk_run_needs_son: assert property ($rose(homing_active) |-> $past(servo_on))
    else $error("run started without servo on");
  // Timeout fault only out of a running state
  chk_fault_cause: assert property ($rose(homing_timeout_fault)
    |-> $past(homing_active)) else $error("fault raised outside a run");
  // Fault means the motor is stopped
  chk_fault_stops: assert property (!(homing_active && homing_timeout_fault))
    else $error("motor running while faulted");
  // Fault stays while servo is on and no start edge arrives
  chk_fault_hold: assert property (homing_timeout_fault && servo_on && !homing_start_input
    |=> homing_timeout_fault) else $error("fault cleared without cause");
  // Done flag needs position control mode
  chk_done_mode: assert property (!position_mode && ce |=> !homing_done_flag)
    else $error("done flag high outside position mode");
  // Done flag rises only after position mode seen
  chk_done_cause: assert property ($rose(homing_done_flag) |-> $past(position_mode))
    else $error("done flag rose without position mode");
  // A fresh run clears the done flag
  chk_run_clears: assert property ($rose(homing_active) |-> !homing_done_flag)
    else $error("done flag kept at run start");
endmodule // hsc_chk

bind hsc_top hsc_chk u_chk (
  .pclk                 (pclk),
  .presetn              (presetn),
  .ce                   (ce),
  .servo_on             (servo_on),
  .homing_start_input   (homing_start_input),
  .home_reached         (home_reached),
  .position_mode        (position_mode),
  .homing_active        (homing_active),
  .homing_done_flag     (homing_done_flag),
  .homing_timeout_fault (homing_timeout_fault)
);

// ==== test/hsc_host_model.sv ====
`timescale 1ns/1ps
// ==================================================================
// Host and motion side: servo enable, start, feedback, position
module hsc_host_model (
  input  wire logic pclk,
  output logic      servo_on,
  output logic      homing_start_input,
  output logic      home_reached,
  output logic      di_position_capture_home,
  output logic [31:0] motor_position
);
  // Idle levels from time zero
  initial begin
    servo_on = 1'h0;
    homing_start_input = 1'h0;
    home_reached = 1'h0;
    di_position_capture_home = 1'h0;
    motor_position = 32'h0000_0000;
  end

  // Servo enable level, held until changed
  task automatic set_servo(input logic v);
    @(posedge pclk);
    servo_on <= v;
  endtask

  // One-cycle start request
  task automatic pulse_start();
    @(posedge pclk);
    homing_start_input <= 1'h1;
    @(posedge pclk);
    homing_start_input <= 1'h0;
  endtask

  // Home found after a chosen delay
  task automatic pulse_home(input int d);
    repeat (d + 1) @(posedge pclk);
    home_reached <= 1'h1;
    @(posedge pclk);
    home_reached <= 1'h0;
  endtask

  // Capture input edge on a mapped input
  task automatic pulse_capture();
    @(posedge pclk);
    di_position_capture_home <= 1'h1;
    @(posedge pclk);
    di_position_capture_home <= 1'h0;
  endtask

  // Encoder position
  task automatic set_pos(input logic [31:0] v);
    @(posedge pclk);
    motor_position <= v;
  endtask
endmodule // hsc_host_model

// ==== test/tb_hsc_top.sv ====
`timescale 1ns/1ps
`include "hsc_cfg.svh"
// ==================================================================
// Testbench of the homing sequencer
module tb_hsc_top;
  logic        pclk, presetn, ce, re, psel, penable, pwrite, pready, pslverr, position_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq, absolute_motor_position, motor_position;
  logic        servo_on, homing_start_input, home_reached, di_position_capture_home;
  logic        homing_active, homing_done_flag, homing_timeout_fault;
  int          fail_count = 0;
  int          n_compared = 0;

  // Clock of 100 ns
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  hsc_host_model host (.pclk(pclk), .servo_on(servo_on),
    .homing_start_input(homing_start_input), .home_reached(home_reached),
    .di_position_capture_home(di_position_capture_home), .motor_position(motor_position));

  hsc_top #(.MS_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .servo_on(servo_on),
    .homing_start_input(homing_start_input), .home_reached(home_reached),
    .position_mode(position_mode), .di_position_capture_home(di_position_capture_home),
    .motor_position(motor_position), .homing_active(homing_active),
    .homing_done_flag(homing_done_flag), .homing_timeout_fault(homing_timeout_fault),
    .absolute_motor_position(absolute_motor_position));

  // ================================================================
  // Reporting
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ================================================================
  // Bus cycles and waits
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (i == 20) begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, rq, re);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0000_0000, rq, re);
    check(nm, rq, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic wait_fault(output int n);
    for (n = 0; n < 60; n++) begin
      if (homing_timeout_fault === 1'h1) return;
      tick(1);
    end
    fail_count++;
    test_done();
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
  endtask

  // ================================================================
  // Main sequence
  initial begin
    int          n;
    presetn = 1'h0;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    position_mode = 1'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(`HSC_OFS_TLIMIT, 32'h0000_2710, "limit_rst");
    apb(1'h0, 12'h018, 32'h0000_0000, rq, re);
    check("unmapped_err", re, 1'h1);
    // Start without servo on, then repeated runs in modes 1 and 2
    wr(`HSC_OFS_TLIMIT, 32'h0000_0002);
    wr(`HSC_OFS_MODE, 32'h0000_0001);
    host.pulse_start();
    tick(1);
    check("no_son_start", homing_active, 1'h0);
    host.set_servo(1'h1);
    for (int m = 1; m <= 2; m++) begin
      wr(`HSC_OFS_MODE, 32'(m));
      for (int k = 0; k < 3; k++) begin
        host.pulse_start();
        tick(1);
        check("run_start", homing_active, 1'h1);
        host.pulse_start();
        tick(1);
        check("retrigger", homing_active, 1'h1);
        host.pulse_home(k);
        tick(1);
        check("run_end", homing_active, 1'h0);
        check("done_set", homing_done_flag, 1'h1);
      end
    end
    // Servo drop mid-run, rerun, timeout and fault clear by start
    host.pulse_start();
    tick(1);
    host.set_servo(1'h0);
    tick(1);
    check("son_drop", homing_active, 1'h0);
    host.set_servo(1'h1);
    host.pulse_start();
    tick(1);
    check("son_rerun", homing_active, 1'h1);
    wait_fault(n);
    check("timeout_len", 32'(n >= 10 && n <= 15), 32'h0000_0001);
    check("fault_stop", homing_active, 1'h0);
    host.pulse_start();
    tick(1);
    check("fault_clear", homing_timeout_fault, 1'h0);
    check("fault_rerun", homing_active, 1'h1);
    host.pulse_home(1);
    host.set_servo(1'h0);
    // Mode 3 runs on the first servo on after reset only
    do_reset();
    wr(`HSC_OFS_MODE, 32'h0000_0003);
    host.set_servo(1'h1);
    tick(1);
    check("first_son", homing_active, 1'h1);
    host.pulse_home(0);
    for (int k = 0; k < 2; k++) begin
      wr(`HSC_OFS_MODE, 32'h0000_0003);
      host.set_servo(1'h0);
      host.set_servo(1'h1);
      tick(1);
      check("later_son", homing_active, 1'h0);
    end
    host.set_servo(1'h0);
    // Modes 4 and 5: automatic start, completion and timeout
    do_reset();
    wr(`HSC_OFS_TLIMIT, 32'h0000_0002);
    for (int m = 4; m <= 5; m++) begin
      wr(`HSC_OFS_MODE, 32'(m));
      host.set_servo(1'h1);
      tick(1);
      check("auto_start", homing_active, 1'h1);
      if (m == 4) begin
        host.set_servo(1'h0);
        tick(1);
        check("auto_halt", homing_active, 1'h0);
        host.set_servo(1'h1);
        tick(1);
        check("auto_rerun", homing_active, 1'h1);
        host.pulse_home(1);
        rd(`HSC_OFS_MODE, 32'h0000_0000, "mode_cleared");
      end else begin
        wait_fault(n);
        rd(`HSC_OFS_MODE, 32'h0000_0000, "mode_zero_fault");
        host.set_servo(1'h0);
        tick(1);
        check("fault_son_clr", homing_timeout_fault, 1'h0);
        host.set_servo(1'h1);
        tick(1);
        check("no_rerun", homing_active, 1'h0);
      end
      host.set_servo(1'h0);
    end
    // Mode 6 with offset applied, then with offset ignored
    host.set_pos(32'h0000_1000);
    wr(`HSC_OFS_OFFSET, 32'h0000_0100);
    wr(`HSC_OFS_OFSTYPE, 32'h0000_0002);
    wr(`HSC_OFS_MODE, 32'h0000_0006);
    tick(2);
    rd(`HSC_OFS_MODE, 32'h0000_0000, "mode6_clear");
    check("abs_home", absolute_motor_position, 32'h0000_0100);
    host.set_pos(32'h0000_1010);
    tick(2);
    check("abs_move", absolute_motor_position, 32'h0000_0110);
    wr(`HSC_OFS_OFFSET, 32'h0000_0200);
    wr(`HSC_OFS_OFSTYPE, 32'h0000_0001);
    wr(`HSC_OFS_MODE, 32'h0000_0006);
    tick(2);
    check("abs_keep_ofs", absolute_motor_position, 32'h0000_0100);
    // Mode 8 captures home on the input edge
    wr(`HSC_OFS_MODE, 32'h0000_0008);
    host.set_pos(32'h0000_2000);
    host.pulse_capture();
    tick(2);
    check("abs_capture", absolute_motor_position, 32'h0000_0100);
    rd(`HSC_OFS_MODE, 32'h0000_0008, "mode8_keep");
    // Clock enable low freezes the reported position, high lets it follow
    @(posedge pclk);
    ce <= 1'h0;
    host.set_pos(32'h0000_3000);
    tick(2);
    check("ce_freeze", absolute_motor_position, 32'h0000_0100);
    @(posedge pclk);
    ce <= 1'h1;
    tick(2);
    check("ce_run", absolute_motor_position, 32'h0000_1100);
    // Done flag drops outside position mode
    @(posedge pclk);
    position_mode <= 1'h0;
    tick(2);
    check("done_pos_mode", homing_done_flag, 1'h0);
    test_done();
  end
endmodule // tb_hsc_top
